// file: core/tpio_defines.svh
// Offsets, field positions, event layout and reset values for the pin I/O block.
`ifndef TPIO_DEFINES_SVH
`define TPIO_DEFINES_SVH

// Register byte offsets on the APB side.
`define TPIO_OFF_CTRL2   12'h000
`define TPIO_OFF_CTRL3   12'h004
`define TPIO_OFF_GR2A    12'h008
`define TPIO_OFF_GR2B    12'h00C
`define TPIO_OFF_GR3A    12'h010
`define TPIO_OFF_GR3B    12'h014
`define TPIO_OFF_EVT     12'h018

// Field positions inside one control byte and inside one field.
`define TPIO_FLD_B_LSB   4
`define TPIO_FLD_A_LSB   0
`define TPIO_FLD_MODE    3
`define TPIO_FLD_LVL     2

// Event status layout: capture flags low, match flags high.
`define TPIO_EVT_CAP_LSB 0
`define TPIO_EVT_MAT_LSB 4

// Reset values.
`define TPIO_RST_CTRL    8'h00
`define TPIO_RST_GR      16'h0000
`define TPIO_RST_EVT     8'h00
`define TPIO_RST_RDATA   32'h0000_0000

`endif

// file: core/tpio_pkg.sv
// Types shared by the pin I/O control block.
package tpio_pkg;

   // One 4-bit mode field and one general register word.
   typedef logic [3:0]  tpio_field_t;
   typedef logic [15:0] tpio_word_t;

   // Compare action selected by the two low field bits.
   typedef enum logic [1:0] {
      TPIO_ACT_NONE   = 2'h0,
      TPIO_ACT_LOW    = 2'h1,
      TPIO_ACT_HIGH   = 2'h2,
      TPIO_ACT_TOGGLE = 2'h3
   } tpio_oc_act_t;

   // Capture edge selected by the two low field bits.
   typedef enum logic [1:0] {
      TPIO_EDGE_RISE  = 2'h0,
      TPIO_EDGE_FALL  = 2'h1,
      TPIO_EDGE_BOTH  = 2'h2,
      TPIO_EDGE_SPARE = 2'h3
   } tpio_ic_edge_t;

endpackage

// file: core/tpio_top.sv
// Timer pin I/O mode control for channels 2 and 3 with an APB slave.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "tpio_defines.svh"
module tpio_top (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel counters and their advance strobes.
   input  wire tpio_pkg::tpio_word_t chan2_count,
   input  wire logic        chan2_count_upd,
   input  wire tpio_pkg::tpio_word_t chan3_count,
   input  wire logic        chan3_count_upd,
   // Channel 2 pins.
   input  wire logic        chan2_pin_a_i,
   output logic             chan2_pin_a_o,
   output logic             chan2_pin_a_oe,
   input  wire logic        chan2_pin_b_i,
   output logic             chan2_pin_b_o,
   output logic             chan2_pin_b_oe,
   // Channel 3 pins.
   input  wire logic        chan3_pin_a_i,
   output logic             chan3_pin_a_o,
   output logic             chan3_pin_a_oe,
   input  wire logic        chan3_pin_b_i,
   output logic             chan3_pin_b_o,
   output logic             chan3_pin_b_oe,
   // Event pulses: bit 0 chan2 A, 1 chan2 B, 2 chan3 A, 3 chan3 B.
   output logic [3:0]       capture_evt,
   output logic [3:0]       match_evt
);
   import tpio_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [7:0]  chan2_pin_io_control_ff;
   logic [7:0]  chan3_pin_io_control_high_ff;
   logic [7:0]  evt_ff;
   logic [7:0]  nxt_evt;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_rdata;
   logic        pslverr_ff;
   logic        nxt_err;
   logic        setup_ph;
   logic        wr_acc;
   logic        hit_ctrl2;
   logic        hit_ctrl3;
   logic        hit_evt;
   logic [3:0]  hit_gr;
   logic        hit_any;

   // Per-unit vectors; index order as for the event ports.
   tpio_field_t fld      [4];
   tpio_word_t  cnt      [4];
   tpio_word_t  gr       [4];
   logic [3:0]  cnt_upd;
   logic [3:0]  fld_wr;
   logic [3:0]  gr_wr;
   logic [3:0]  pin_i;
   logic [3:0]  pin_o;
   logic [3:0]  pin_oe;
   logic [3:0]  cap;
   logic [3:0]  mat;

   ////////////////////////////////////////////////////////////////////////
   // APB decode. Zero wait states: the access phase always completes.

   assign setup_ph  = psel & ~penable;
   assign wr_acc    = psel & penable & pwrite;
   assign hit_ctrl2 = (paddr == `TPIO_OFF_CTRL2);
   assign hit_ctrl3 = (paddr == `TPIO_OFF_CTRL3);
   assign hit_evt   = (paddr == `TPIO_OFF_EVT);
   assign hit_gr[0] = (paddr == `TPIO_OFF_GR2A);
   assign hit_gr[1] = (paddr == `TPIO_OFF_GR2B);
   assign hit_gr[2] = (paddr == `TPIO_OFF_GR3A);
   assign hit_gr[3] = (paddr == `TPIO_OFF_GR3B);
   assign hit_any   = hit_ctrl2 | hit_ctrl3 | hit_evt | (|hit_gr);

   // Handshake output; completes in the first access cycle.
   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Control registers.

   // Channel 2 byte: B field in the upper nibble, A in the lower.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan2_pin_io_control_ff <= `TPIO_RST_CTRL;
      end else if (wr_acc && hit_ctrl2) begin
         chan2_pin_io_control_ff <= pwdata[7:0];
      end
   end

   // Channel 3 byte, same layout and encoding.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan3_pin_io_control_high_ff <= `TPIO_RST_CTRL;
      end else if (wr_acc && hit_ctrl3) begin
         chan3_pin_io_control_high_ff <= pwdata[7:0];
      end
   end

   // Split the bytes into fields; a write strobes both fields of a byte
   // so each field holding a compare code reloads its initial pin level.
   assign fld[0]    = chan2_pin_io_control_ff[`TPIO_FLD_A_LSB +: 4];
   assign fld[1]    = chan2_pin_io_control_ff[`TPIO_FLD_B_LSB +: 4];
   assign fld[2]    = chan3_pin_io_control_high_ff[`TPIO_FLD_A_LSB +: 4];
   assign fld[3]    = chan3_pin_io_control_high_ff[`TPIO_FLD_B_LSB +: 4];
   assign fld_wr[0] = wr_acc & hit_ctrl2;
   assign fld_wr[1] = wr_acc & hit_ctrl2;
   assign fld_wr[2] = wr_acc & hit_ctrl3;
   assign fld_wr[3] = wr_acc & hit_ctrl3;

   // The level load must see the new byte, so the unit gets the field
   // one cycle late; delaying the strobe keeps the two aligned.
   logic [3:0] fld_wr_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fld_wr_ff <= 4'h0;
      else          fld_wr_ff <= fld_wr;
   end

   // General register software writes.
   assign gr_wr = {4{wr_acc}} & hit_gr;

   // Counters and pins per unit.
   assign cnt[0]  = chan2_count;
   assign cnt[1]  = chan2_count;
   assign cnt[2]  = chan3_count;
   assign cnt[3]  = chan3_count;
   assign cnt_upd = {chan3_count_upd, chan3_count_upd,
                     chan2_count_upd, chan2_count_upd};
   assign pin_i   = {chan3_pin_b_i, chan3_pin_a_i,
                     chan2_pin_b_i, chan2_pin_a_i};

   ////////////////////////////////////////////////////////////////////////
   // Four general register units.

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_unit
         tpio_unit u_unit (
            .pclk      (pclk),
            .presetn   (presetn),
            .field     (fld[gi]),
            .field_wr  (fld_wr_ff[gi]),
            .count     (cnt[gi]),
            .count_upd (cnt_upd[gi]),
            .gr_wr     (gr_wr[gi]),
            .gr_wdata  (pwdata[15:0]),
            .pin_i     (pin_i[gi]),
            .pin_o     (pin_o[gi]),
            .pin_oe    (pin_oe[gi]),
            .gr        (gr[gi]),
            .match     (mat[gi]),
            .capture   (cap[gi])
         );
      end
   endgenerate

   // Pin fan-out.
   assign chan2_pin_a_o  = pin_o[0];
   assign chan2_pin_a_oe = pin_oe[0];
   assign chan2_pin_b_o  = pin_o[1];
   assign chan2_pin_b_oe = pin_oe[1];
   assign chan3_pin_a_o  = pin_o[2];
   assign chan3_pin_a_oe = pin_oe[2];
   assign chan3_pin_b_o  = pin_o[3];
   assign chan3_pin_b_oe = pin_oe[3];
   assign capture_evt    = cap;
   assign match_evt      = mat;

   ////////////////////////////////////////////////////////////////////////
   // Event status: sticky, write one to clear, a new event beats a clear.

   always_comb begin
      nxt_evt = evt_ff;
      if (wr_acc && hit_evt) begin
         nxt_evt = evt_ff & ~pwdata[7:0];
      end
      nxt_evt[`TPIO_EVT_CAP_LSB +: 4] = nxt_evt[`TPIO_EVT_CAP_LSB +: 4] | cap;
      nxt_evt[`TPIO_EVT_MAT_LSB +: 4] = nxt_evt[`TPIO_EVT_MAT_LSB +: 4] | mat;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) evt_ff <= `TPIO_RST_EVT;
      else          evt_ff <= nxt_evt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data is taken in the setup cycle so prdata comes from a flop;
   // an event landing in that same cycle shows on the next read.

   always_comb begin
      nxt_rdata = `TPIO_RST_RDATA;
      nxt_err   = ~hit_any;
      case (1'b1)
         hit_ctrl2: nxt_rdata[7:0]  = chan2_pin_io_control_ff;
         hit_ctrl3: nxt_rdata[7:0]  = chan3_pin_io_control_high_ff;
         hit_gr[0]: nxt_rdata[15:0] = gr[0];
         hit_gr[1]: nxt_rdata[15:0] = gr[1];
         hit_gr[2]: nxt_rdata[15:0] = gr[2];
         hit_gr[3]: nxt_rdata[15:0] = gr[3];
         hit_evt:   nxt_rdata[7:0]  = evt_ff;
         default:   nxt_rdata       = `TPIO_RST_RDATA;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= `TPIO_RST_RDATA;
         pslverr_ff <= 1'b0;
      end else if (setup_ph) begin
         prdata_ff  <= pwrite ? `TPIO_RST_RDATA : nxt_rdata;
         pslverr_ff <= nxt_err;
      end
   end

   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff & psel & penable;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A write to the channel 2 byte lands in both fields.
   AST_CTRL2_WRITE: assert property (
      (wr_acc && hit_ctrl2)
      |=> fld[1] == $past(pwdata[7:4]) && fld[0] == $past(pwdata[3:0]))
      else $error("channel 2 fields not written");

   AST_CTRL3_WRITE: assert property (
      (wr_acc && hit_ctrl3)
      |=> fld[3] == $past(pwdata[7:4]) && fld[2] == $past(pwdata[3:0]))
      else $error("channel 3 fields not written");

   // After a channel 2 byte write, a disabled code keeps the B pin off.
   AST_CTRL2_B_OFF: assert property (
      (wr_acc && hit_ctrl2 && pwdata[7] == 1'b0 && pwdata[5:4] == 2'h0)
      |=> !chan2_pin_b_oe)
      else $error("channel 2 B pin driven while disabled");

   // Compare code with initial level: pin level settles two edges on.
   AST_CTRL3_A_LEVEL: assert property (
      (wr_acc && hit_ctrl3 && !pwdata[3] && pwdata[1:0] != 2'h0)
      ##1 !(wr_acc && hit_ctrl3)
      |=> chan3_pin_a_oe && chan3_pin_a_o == $past(pwdata[2], 2))
      else $error("channel 3 A initial level wrong");

   // A capture pulse leaves its status flag set on the next edge.
   AST_EVT_STICKY: assert property (
      cap[0] |=> evt_ff[`TPIO_EVT_CAP_LSB])
      else $error("capture flag not set");

   // Unmapped addresses answer with an error.
   AST_APB_ERR: assert property (
      (setup_ph && !hit_any) |=> (psel && penable) |-> pslverr)
      else $error("unmapped access not flagged");

   COV_WRITE_CTRL2: cover property (wr_acc && hit_ctrl2);
   COV_CAPTURE_C3:  cover property (capture_evt[3]);
   COV_MATCH_C2:    cover property (match_evt[0]);

endmodule // tpio_top

// file: core/tpio_unit.sv
// One general register with its compare or capture pin logic.
`timescale 1ns/1ps
`include "tpio_defines.svh"
module tpio_unit (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Mode field and its write strobe.
   input  wire tpio_pkg::tpio_field_t field,
   input  wire logic              field_wr,
   // Channel counter and its advance strobe.
   input  wire tpio_pkg::tpio_word_t  count,
   input  wire logic              count_upd,
   // Software write of the general register.
   input  wire logic              gr_wr,
   input  wire tpio_pkg::tpio_word_t  gr_wdata,
   // Timer pin.
   input  wire logic              pin_i,
   output logic                   pin_o,
   output logic                   pin_oe,
   // Register contents and events.
   output tpio_pkg::tpio_word_t   gr,
   output logic                   match,
   output logic                   capture
);
   import tpio_pkg::*;

   tpio_word_t    gr_ff;
   logic          pin_prev_ff;
   logic          out_ff;
   logic          match_ff;
   logic          cap_ff;
   logic          cap_mode;
   logic          rise;
   logic          fall;
   logic          cap_now;
   logic          match_now;
   tpio_oc_act_t  act;
   tpio_ic_edge_t edge_sel;

   // Decode of the field and of the pin edges.
   assign cap_mode = field[`TPIO_FLD_MODE];
   assign act      = tpio_oc_act_t'(field[1:0]);
   assign edge_sel = tpio_ic_edge_t'(field[1:0]);
   assign rise     = pin_i & ~pin_prev_ff;
   assign fall     = ~pin_i & pin_prev_ff;

   // Capture edge choice; the level bit plays no part here.
   always_comb begin
      case (edge_sel)
         TPIO_EDGE_RISE: cap_now = cap_mode & rise;
         TPIO_EDGE_FALL: cap_now = cap_mode & fall;
         TPIO_EDGE_BOTH: cap_now = cap_mode & (rise | fall);
         default:        cap_now = cap_mode & (rise | fall);
      endcase
   end

   // Match only on a counter advance, so a stopped counter fires once.
   assign match_now = ~cap_mode & count_upd & (count == gr_ff);

   // Pin history for edge detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pin_prev_ff <= 1'b0;
      else          pin_prev_ff <= pin_i;
   end

   // General register: a capture beats a software write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)     gr_ff <= `TPIO_RST_GR;
      else if (cap_now) gr_ff <= count;
      else if (gr_wr)   gr_ff <= gr_wdata;
   end

   // Pin level: a field write with a compare code loads the initial level first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= 1'b0;
      end else if (field_wr && !field[`TPIO_FLD_MODE]) begin
         out_ff <= field[`TPIO_FLD_LVL];
      end else if (match_now) begin
         case (act)
            TPIO_ACT_LOW:    out_ff <= 1'b0;
            TPIO_ACT_HIGH:   out_ff <= 1'b1;
            TPIO_ACT_TOGGLE: out_ff <= ~out_ff;
            default:         out_ff <= out_ff;
         endcase
      end
   end

   // Event pulses, registered one cycle after the cause.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_ff <= 1'b0;
         cap_ff   <= 1'b0;
      end else begin
         match_ff <= match_now;
         cap_ff   <= cap_now;
      end
   end

   // Drive only as a compare register with an action chosen.
   assign pin_oe  = ~cap_mode & (act != TPIO_ACT_NONE);
   assign pin_o   = out_ff;
   assign gr      = gr_ff;
   assign match   = match_ff;
   assign capture = cap_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Rising edge capture copies the counter and raises the pulse.
   AST_CAP_RISE: assert property (
      (cap_mode && edge_sel == TPIO_EDGE_RISE && rise)
      |=> (gr == $past(count)) && capture)
      else $error("rising edge not captured");

   AST_CAP_FALL: assert property (
      (cap_mode && edge_sel == TPIO_EDGE_FALL && (rise || fall))
      |=> (capture == $past(fall)))
      else $error("falling edge capture wrong");

   AST_CAP_BOTH: assert property (
      (cap_mode && edge_sel[1] && (rise || fall))
      |=> capture && gr == $past(count))
      else $error("both edge capture missed");

   AST_CAP_NO_DRIVE: assert property (
      cap_mode |-> !pin_oe)
      else $error("pin driven in capture mode");

   AST_MATCH_LOW: assert property (
      (match_now && act == TPIO_ACT_LOW && !field_wr) |=> !pin_o ##1 1)
      else $error("pin not low after match");

   AST_MATCH_HIGH: assert property (
      (match_now && act == TPIO_ACT_HIGH && !field_wr) |=> pin_o && match)
      else $error("pin not high after match");

   AST_MATCH_TOGGLE: assert property (
      (match_now && act == TPIO_ACT_TOGGLE && !field_wr)
      |=> pin_o != $past(pin_o))
      else $error("pin not toggled after match");

   AST_INIT_LEVEL: assert property (
      (field_wr && !field[3]) |=> pin_o == $past(field[2]))
      else $error("initial level not loaded");

   AST_OUT_DISABLED: assert property (
      (!field[3] && field[1:0] == 2'h0) |-> !pin_oe)
      else $error("pin driven while disabled");

   COV_TOGGLE: cover property (match_now && act == TPIO_ACT_TOGGLE);
   COV_BOTH:   cover property (cap_now && edge_sel == TPIO_EDGE_BOTH);

endmodule // tpio_unit

// file: tb/tpio_pin_model.sv
// Board-side model of the four timer pins.
`timescale 1ns/1ps
module tpio_pin_model (
   // Levels the board would drive and the device's pin outputs.
   input  wire logic [3:0] ext_lvl,
   input  wire logic [3:0] pin_o,
   input  wire logic [3:0] pin_oe,
   // Resolved pin levels fed back to the device.
   output logic      [3:0] pin_i
);
   // The device owns a pin while it drives it; the board only fills in a
   // released pin, so a compare output is never fought by the stimulus.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pin_i[k] = pin_oe[k] ? pin_o[k] : ext_lvl[k];
      end
   end
endmodule // tpio_pin_model

// file: tb/tpio_top_tb.sv
// Self-checking bench for the timer pin I/O mode control block.
`timescale 1ns/1ps
`include "tpio_defines.svh"
module tpio_top_tb;
   import tpio_pkg::*;
   logic        pclk    = 1'h0;
   logic        presetn = 1'h0;
   logic        psel    = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite  = 1'h0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   tpio_word_t  cnt2    = 16'h0;
   tpio_word_t  cnt3    = 16'h0;
   logic        upd2    = 1'h0;
   logic        upd3    = 1'h0;
   logic [3:0]  ext     = 4'h0;
   logic [3:0]  pin_i;
   logic [3:0]  pin_o;
   logic [3:0]  pin_oe;
   logic [3:0]  cap_evt;
   logic [3:0]  mat_evt;
   logic [32:0] exp_q[$];
   int          n_fail    = 0;
   int          cmp_count = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, device and pin model.
   always #12.5 pclk = ~pclk;

   tpio_top u_tpio_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .chan2_count(cnt2), .chan2_count_upd(upd2),
      .chan3_count(cnt3), .chan3_count_upd(upd3),
      .chan2_pin_a_i(pin_i[0]), .chan2_pin_a_o(pin_o[0]),
      .chan2_pin_a_oe(pin_oe[0]), .chan2_pin_b_i(pin_i[1]),
      .chan2_pin_b_o(pin_o[1]), .chan2_pin_b_oe(pin_oe[1]),
      .chan3_pin_a_i(pin_i[2]), .chan3_pin_a_o(pin_o[2]),
      .chan3_pin_a_oe(pin_oe[2]), .chan3_pin_b_i(pin_i[3]),
      .chan3_pin_b_o(pin_o[3]), .chan3_pin_b_oe(pin_oe[3]),
      .capture_evt(cap_evt), .match_evt(mat_evt));

   tpio_pin_model u_tpio_pin_model (
      .ext_lvl(ext), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and unit address helpers.
   task automatic chk(input string what, input logic [32:0] e, g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", what, e, g);
         n_fail++;
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [11:0] ca(input int u);
      return (u < 2) ? `TPIO_OFF_CTRL2 : `TPIO_OFF_CTRL3;
   endfunction

   function automatic logic [11:0] ga(input int u);
      return `TPIO_OFF_GR2A + 12'(4 * u);
   endfunction

   function automatic int sh(input int u);
      return (u % 2) ? `TPIO_FLD_B_LSB : `TPIO_FLD_A_LSB;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB master; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      // Only a wait that ends without pready is a hang.
      if (pready !== 1'h1) begin
         n_fail++;
         conclude();
      end else begin
         psel    <= 1'h0;
         penable <= 1'h0;
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'h0, a, 32'h0);
   endtask

   // Read answers are judged apart from the driver, oldest note first.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite) begin
         if (exp_q.size() > 0) begin
            chk("read", exp_q.pop_front(), {pslverr, prdata});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event counting over a short window; pulses last one cycle.
   // An unknown pulse counts as a hit, so it cannot slip past a miss check.
   task automatic count_evt(input int u, input bit cap, output int hits);
      hits = 0;
      repeat (6) begin
         #1;
         if ((cap ? cap_evt[u] : mat_evt[u]) !== 1'h0) begin
            hits++;
         end
         @(posedge pclk);
      end
   endtask

   task automatic drive_cnt(input int u, input tpio_word_t v,
                            input logic up, output int hits);
      @(posedge pclk);
      if (u < 2) begin
         cnt2 <= v;
         upd2 <= up;
      end else begin
         cnt3 <= v;
         upd3 <= up;
      end
      @(posedge pclk);
      upd2 <= 1'h0;
      upd3 <= 1'h0;
      count_evt(u, 1'h0, hits);
   endtask

   task automatic flip_pin(input int u, output int hits);
      @(posedge pclk);
      ext <= ext ^ (4'h1 << u);
      count_evt(u, 1'h1, hits);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset state, capture modes, compare modes, reset again.
   initial begin
      int         hr;
      int         hf;
      int         e;
      tpio_word_t g;
      void'($urandom(32'hEBC8));
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      #1;
      chk("oe", 33'h0, {29'h0, pin_oe});
      for (int r = 0; r < 7; r++) begin
         rd(12'(4 * r), 33'h0);
      end
      apb(1'h1, 12'h01C, 32'hFFFF_FFFF);
      rd(12'h01C, {1'h1, 32'h0});
      $display("test reset done");
      for (int u = 0; u < 4; u++) begin
         for (int c = 8; c < 16; c++) begin
            apb(1'h1, ca(u), 32'(c << sh(u)));
            rd(ca(u), 33'(c << sh(u)));
            g = 16'($urandom);
            drive_cnt(u, g, 1'h0, hr);
            flip_pin(u, hr);
            flip_pin(u, hf);
            chk("rise", 33'(c % 4 != 1), 33'(hr));
            chk("fall", 33'(c % 4 != 0), 33'(hf));
            rd(ga(u), {17'h0, g});
         end
      end
      $display("test capture done");
      for (int u = 0; u < 4; u++) begin
         for (int c = 0; c < 8; c++) begin
            g = 16'($urandom);
            apb(1'h1, ga(u), {16'h0, g});
            apb(1'h1, ca(u), 32'(c << sh(u)));
            repeat (2) @(posedge pclk);
            #1;
            chk("oe", 33'(c % 4 != 0), 33'(pin_oe[u]));
            if (c % 4 != 0) begin
               chk("init", 33'(c / 4), 33'(pin_o[u]));
            end
            drive_cnt(u, g + 16'h1, 1'h1, hr);
            chk("miss", 33'h0, 33'(hr));
            drive_cnt(u, g, 1'h1, hr);
            chk("match", 33'h1, 33'(hr));
            e = (c % 4 == 1) ? 0 : (c % 4 == 2) ? 1 : 1 - c / 4;
            if (c % 4 != 0) begin
               chk("pin", 33'(e), 33'(pin_o[u]));
            end
         end
      end
      $display("test compare done");
      // Every unit has captured and matched; clear only the capture half.
      rd(`TPIO_OFF_EVT, {25'h0, 8'hFF});
      apb(1'h1, `TPIO_OFF_EVT, 32'h0000_000F);
      rd(`TPIO_OFF_EVT, {25'h0, 8'hF0});
      $display("test event status done");
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      #1;
      chk("pins", 33'h0, {25'h0, pin_o, pin_oe});
      @(posedge pclk);
      presetn <= 1'h1;
      rd(`TPIO_OFF_CTRL3, 33'h0);
      rd(`TPIO_OFF_EVT, 33'h0);
      repeat (2) @(posedge pclk);
      chk("pending", 33'h0, 33'(exp_q.size()));
      $display("test second reset done");
      conclude();
   end

   // A hang anywhere ends the run as a mismatch.
   initial begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      conclude();
   end
endmodule // tpio_top_tb
